// [sc_card_model.sv]
/* Card on the I/O line: sends frames, captures frames, answers with a break.
   Assumes an open-drain line with pull-up and the shared half-ETU tick. */
`timescale 1ns/1ps
module sc_card_model (
  input wire logic mclk,
  input wire logic etu_half_tick,
  input wire logic line,
  output logic card_oe
);
  initial card_oe = 1'b0;
  task automatic tick(input int n);
    repeat (n) begin
      do @(posedge mclk); while (!etu_half_tick);
    end
  endtask : tick
  // Start, eight data LSB first, parity
  task automatic send(input logic [8:0] f);
    tick(1);
    card_oe <= 1'b1;
    tick(2);
    for (int i = 0; i < 9; i++) begin
      card_oe <= ~f[i];
      tick(2);
    end
    card_oe <= 1'b0;
  endtask : send
  // Mid-bit sampling; optional break across the 11 ETU point
  task automatic get(output logic [8:0] f, input logic brk);
    do @(posedge mclk); while (line);
    tick(1);
    for (int i = 0; i < 9; i++) begin
      tick(2);
      f[i] = line;
    end
    tick(2);
    card_oe <= brk;
    tick(3);
    card_oe <= 1'b0;
  endtask : get
endmodule : sc_card_model

// [sc_char_cfg.svh]
/*
  Constants of the smart card character engine: register offsets, field
  positions, reset values and character timing in half-ETU steps.
  Assumes the ETU divider delivers one pulse per half ETU on mclk.
*/
`ifndef SC_CHAR_CFG_SVH
`define SC_CHAR_CFG_SVH
`define ADDR_PARITY_BREAK_CONTROL 16'hFE11
`define ADDR_CHAR_TS_CONTROL 16'hFE12
`define RST_PARITY_BREAK_CONTROL 8'h00
`define RST_CHAR_TS_CONTROL 8'h2C
`define CTS_WRITE_MASK 8'h78
`define BIT_PARITY_CHECK_OFF 6
`define BIT_BREAK_GEN_OFF 5
`define BIT_BREAK_DETECT_OFF 4
`define BIT_RESEND_ON_BREAK 3
`define BIT_DROP_BAD_RX_CHAR 2
`define BIT_TX_PARITY_ERROR_INJECT 1
`define BIT_RX_PARITY_ERROR_FORCE 0
`define BIT_INITIAL_CHAR_DETECT 6
`define BIT_DIRECT_CONVENTION_FLAG 5
`define BIT_BREAK_LENGTH_HI 4
`define BIT_BREAK_LENGTH_LO 3
`define HALF_BIT 6'h02
`define HALF_CHAR_END 6'h14
`define HALF_BREAK_START 6'h15
`define HALF_BREAK_SAMPLE 6'h16
`define HALF_TX_END 6'h18
`define HALF_BREAK_1ETU 6'h02
`define HALF_BREAK_1P5ETU 6'h03
`define HALF_BREAK_2ETU 6'h04
`define TS_RAW_INVERSE 8'h03
`endif

// [sc_char_checker.sv]
/* Port assertions for the character engine.
   Assumes a half-ETU tick every 8 mclk cycles. */
`timescale 1ns/1ps
`include "sc_char_cfg.svh"
module sc_char_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic protocol_select,
  input wire logic io_oe,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire logic rx_parity_err,
  input wire logic break_detected
);
  logic [7:0] pbc_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Shadow copy, bit 7 reads 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) pbc_r <= 8'h00;
    else if (reg_wr && reg_addr == `ADDR_PARITY_BREAK_CONTROL) pbc_r <= reg_wdata & 8'h7F;
  end
  a_pbc_readback: assert property (reg_rd && reg_addr == `ADDR_PARITY_BREAK_CONTROL |=> reg_rdata == pbc_r)
    else $error("control readback wrong");
  a_perr_gated: assert property (rx_valid && pbc_r[6] |-> !rx_parity_err)
    else $error("parity error while check off");
  a_force_err: assert property (rx_valid && !pbc_r[6] && pbc_r[0] |-> rx_parity_err)
    else $error("forced parity error missing");
  a_drop_bad: assert property (rx_valid && rx_parity_err |-> !(pbc_r[2] && !protocol_select))
    else $error("bad character kept");
  a_break_start: assert property (rx_valid && rx_parity_err && !protocol_select && !pbc_r[5]
    |-> !io_oe ##[6:10] io_oe)
    else $error("break not driven");
  a_no_break: assert property (rx_valid && (pbc_r[6] || pbc_r[5] || protocol_select)
    |-> !io_oe [*8] ##1 !io_oe [*8])
    else $error("break driven when not allowed");
  a_detect_t0: assert property (break_detected |-> !protocol_select && !pbc_r[4])
    else $error("break detected outside T=0");
  a_detect_quiet: assert property (break_detected |-> !io_oe && !$past(io_oe))
    else $error("break sampled while driving");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid && !tx_done)
    else $error("receive pulse too long");
endmodule : sc_char_checker

bind sc_char_engine sc_char_checker u_chk (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .protocol_select, .io_oe, .tx_done, .rx_valid, .rx_parity_err, .break_detected);

// [sc_char_engine.sv]
/*
  Character engine of the smart card UART: parity, T=0 break handling,
  resend, discard, test error injection and TS convention detection.
  Assumes a half-ETU tick from the ETU divider on mclk, an open-drain
  I/O line with external pull-up, and a receive FIFO that always accepts.
*/
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "sc_char_cfg.svh"
module sc_char_engine
  import sc_char_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic protocol_select,
  input wire logic etu_half_tick,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic tx_done,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic break_detected
);
  char_regs_type r;
  char_regs_type n;
  logic t0_mode;
  logic chk_on;
  logic inverse;
  logic [7:0] raw_byte;
  logic [7:0] dec_byte;
  logic raw_par;
  logic par_err;
  logic ts_inverse;
  logic use_inverse;
  logic want_break;
  logic [5:0] brk_len;
  logic [7:0] line_byte;
  logic line_par;
  logic [8:0] tx_frame;
  logic start_edge;

  // Bit-reverse and invert, the inverse convention mapping both ways
  function automatic logic [7:0] inv_map(input logic [7:0] b);
    logic [7:0] o;
    o = 8'h00;
    for (int i = 0; i < 8; i++) begin
      o[i] = ~b[7 - i];
    end
    return o;
  endfunction : inv_map

  always_comb begin
    n = r;
    n.io_meta = io_in;
    n.io_sync = r.io_meta;
    n.io_prev = r.io_sync;
    n.rx_valid = 1'b0;
    n.rx_parity_err = 1'b0;
    n.break_detected = 1'b0;
    n.tx_done = 1'b0;
    n.rdata = 8'h00;

    t0_mode = ~protocol_select;
    chk_on = ~r.pbc[`BIT_PARITY_CHECK_OFF];
    inverse = ~r.cts[`BIT_DIRECT_CONVENTION_FLAG];
    start_edge = r.io_prev & ~r.io_sync;

    // Received frame: shreg[7:0] line data LSB first, shreg[8] parity
    raw_byte = r.shreg[7:0];
    raw_par = r.shreg[8];
    ts_inverse = (raw_byte == `TS_RAW_INVERSE);
    use_inverse = r.ts_now ? ts_inverse : inverse;
    dec_byte = use_inverse ? inv_map(raw_byte) : raw_byte;
    // Inverted line flips nine bits, so even becomes odd
    par_err = ((^{raw_par, raw_byte}) ^ use_inverse) | r.pbc[`BIT_RX_PARITY_ERROR_FORCE];
    want_break = par_err & chk_on & t0_mode & ~r.pbc[`BIT_BREAK_GEN_OFF];

    case (r.cts[`BIT_BREAK_LENGTH_HI:`BIT_BREAK_LENGTH_LO])
      2'b00: brk_len = `HALF_BREAK_1ETU;
      2'b01: brk_len = `HALF_BREAK_1P5ETU;
      2'b10: brk_len = `HALF_BREAK_2ETU;
      default: brk_len = `HALF_BREAK_1ETU; // Reserved code falls back to shortest
    endcase

    // Transmit frame in line order with parity
    line_byte = inverse ? inv_map(r.tx_byte) : r.tx_byte;
    line_par = (^r.tx_byte) ^ inverse ^ r.pbc[`BIT_TX_PARITY_ERROR_INJECT];
    tx_frame = {line_par, line_byte};

    if (etu_half_tick && r.cnt != 6'h3F) begin
      n.cnt = r.cnt + 6'h01;
    end

    case (r.st)
      ST_IDLE: begin
        n.io_oe = 1'b0;
        n.ts_now = r.cts[`BIT_INITIAL_CHAR_DETECT];
        if (start_edge) begin
          n.st = ST_RX_BITS;
          n.cnt = 6'h00;
          n.shreg = 9'h000;
        end else if (tx_valid && etu_half_tick) begin
          // Start only on a tick so the start bit lasts a full ETU
          n.st = ST_TX_BITS;
          n.tx_byte = tx_data;
          n.cnt = 6'h00;
          n.io_oe = 1'b1;
        end
      end
      ST_RX_BITS: begin
        // Mid-bit samples at odd half counts; 3..19 are data and parity
        if (etu_half_tick && r.cnt[0] == 1'b0 && r.cnt >= 6'h02 && r.cnt < `HALF_CHAR_END) begin
          n.shreg = {r.io_sync, r.shreg[8:1]};
        end
        if (r.cnt == `HALF_CHAR_END) begin
          if (r.ts_now) begin
            n.cts[`BIT_DIRECT_CONVENTION_FLAG] = ~ts_inverse;
            n.cts[`BIT_INITIAL_CHAR_DETECT] = 1'b0;
            n.ts_now = 1'b0;
          end
          if (!(par_err && chk_on && t0_mode && r.pbc[`BIT_DROP_BAD_RX_CHAR])) begin
            n.rx_valid = 1'b1;
            n.rx_data = dec_byte;
            n.rx_parity_err = par_err & chk_on;
          end
          n.st = want_break ? ST_RX_BREAK : ST_RX_WAIT;
        end
      end
      ST_RX_BREAK: begin
        // Break runs from 10.5 ETU for the selected length
        n.io_oe = (n.cnt >= `HALF_BREAK_START) && (n.cnt < `HALF_BREAK_START + brk_len);
        if (r.cnt >= `HALF_BREAK_START + brk_len) begin
          n.io_oe = 1'b0;
          n.st = ST_RX_WAIT;
        end
      end
      ST_RX_WAIT: begin
        n.io_oe = 1'b0;
        if (r.io_sync) begin
          n.st = ST_IDLE;
        end
      end
      ST_TX_BITS: begin
        // Start bit for one ETU, then nine frame bits
        if (r.cnt < `HALF_BIT) begin
          n.io_oe = (n.cnt < `HALF_BIT) ? 1'b1 : ~tx_frame[0];
        end else begin
          n.io_oe = (n.cnt < `HALF_CHAR_END) ? ~tx_frame[4'(n.cnt[5:1] - 5'h01)] : 1'b0;
        end
        if (r.cnt == `HALF_CHAR_END) begin
          n.io_oe = 1'b0;
          n.card_break = 1'b0;
          n.st = ST_TX_CHECK;
        end
      end
      ST_TX_CHECK: begin
        n.io_oe = 1'b0;
        // Sample on the tick that completes 22 half ETUs
        if (etu_half_tick && n.cnt == `HALF_BREAK_SAMPLE && t0_mode && !r.pbc[`BIT_BREAK_DETECT_OFF]) begin
          n.card_break = ~r.io_sync;
          n.break_detected = ~r.io_sync;
        end
        // Guard time and released line before the next character
        if (etu_half_tick && r.cnt >= `HALF_TX_END && r.io_sync) begin
          if (r.card_break && r.pbc[`BIT_RESEND_ON_BREAK]) begin
            n.st = ST_TX_BITS;
            n.cnt = 6'h00;
            n.io_oe = 1'b1;
          end else begin
            n.tx_done = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.io_oe = 1'b0;
      end
    endcase

    // Register port; hardware update of the convention bits wins
    if (reg_wr && reg_addr == `ADDR_PARITY_BREAK_CONTROL) begin
      n.pbc = reg_wdata & 8'h7F;
    end
    if (reg_wr && reg_addr == `ADDR_CHAR_TS_CONTROL) begin
      n.cts = (r.cts & ~`CTS_WRITE_MASK) | (reg_wdata & `CTS_WRITE_MASK);
      if (r.st == ST_RX_BITS && r.cnt == `HALF_CHAR_END && r.ts_now) begin
        n.cts[`BIT_DIRECT_CONVENTION_FLAG] = ~ts_inverse;
        n.cts[`BIT_INITIAL_CHAR_DETECT] = 1'b0;
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_PARITY_BREAK_CONTROL: n.rdata = r.pbc;
        `ADDR_CHAR_TS_CONTROL: n.rdata = r.cts;
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.io_meta <= 1'b1;
      r.io_sync <= 1'b1;
      r.io_prev <= 1'b1;
      r.pbc <= `RST_PARITY_BREAK_CONTROL;
      r.cts <= `RST_CHAR_TS_CONTROL;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign io_out = 1'b0;
  assign io_oe = r.io_oe;
  assign tx_ready = (r.st == ST_IDLE) && !start_edge && etu_half_tick;
  assign tx_done = r.tx_done;
  assign rx_valid = r.rx_valid;
  assign rx_data = r.rx_data;
  assign rx_parity_err = r.rx_parity_err;
  assign break_detected = r.break_detected;
endmodule : sc_char_engine

// [sc_char_pkg.sv]
/*
  Types of the smart card character engine.
  Assumes sc_char_cfg.svh supplies all numeric constants.
*/
package sc_char_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX_BITS = 6'h02,
    ST_RX_BREAK = 6'h04,
    ST_RX_WAIT = 6'h08,
    ST_TX_BITS = 6'h10,
    ST_TX_CHECK = 6'h20
  } char_state_type;

  typedef struct packed {
    char_state_type st;
    logic [5:0] cnt;
    logic [8:0] shreg;
    logic [7:0] tx_byte;
    logic io_meta;
    logic io_sync;
    logic io_prev;
    logic [7:0] pbc;
    logic [7:0] cts;
    logic [7:0] rdata;
    logic io_oe;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_parity_err;
    logic break_detected;
    logic tx_done;
    logic ts_now;
    logic card_break;
  } char_regs_type;
endpackage : sc_char_pkg

// [smart_card_char_error_control_tb.sv]
/* Self-checking bench for the character engine with a card model on the line.
   Assumes a 64 ns half-ETU tick and a pull-up on the I/O line. */
`timescale 1ns/1ps
`include "sc_char_cfg.svh"
module smart_card_char_error_control_tb;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, protocol_select = 0, etu_half_tick = 0, tx_valid = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, tx_data = 0, reg_rdata, rx_data, last_d, cfg;
  logic io_out, io_oe, tx_ready, tx_done, rx_valid, rx_parity_err, break_detected, card_oe, last_e, bad, err;
  logic [2:0] div = 0;
  logic [8:0] f;
  logic [31:0] lfsr = 32'h295E;
  int num_errors = 0, tests_run = 0, nrx = 0, ndone = 0, nbrk = 0, oe_cyc = 0;
  int blen[4] = '{2, 3, 4, 2};
  wire line = !(io_oe || card_oe);
  sc_char_engine dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .protocol_select,
    .etu_half_tick, .io_in(line), .io_out, .io_oe, .tx_valid, .tx_data, .tx_ready, .tx_done, .rx_valid,
    .rx_data, .rx_parity_err, .break_detected);
  sc_card_model u_card (.mclk, .etu_half_tick, .line, .card_oe);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    div <= div + 3'h1;
    etu_half_tick <= (div == 3'h7);
    oe_cyc += int'(io_oe);
    ndone += int'(tx_done);
    nbrk += int'(break_detected);
    if (rx_valid === 1'b1) begin
      nrx++;
      last_d = rx_data;
      last_e = rx_parity_err;
    end
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  function automatic logic [8:0] frame(input logic [7:0] d, input logic odd);
    return {^d ^ odd, d};
  endfunction : frame
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata === e, "register read");
  endtask : rd
  task automatic rx(input logic [8:0] fr, input logic [7:0] ed, input logic ev, input logic ee);
    int n0;
    n0 = nrx;
    u_card.send(fr);
    u_card.tick(10);
    chk(nrx == n0 + int'(ev), "receive count");
    if (ev) chk(last_d === ed && last_e === ee, "receive byte");
  endtask : rx
  task automatic tx(input logic [7:0] d, input logic brk, input logic odd);
    int d0, b0;
    d0 = ndone;
    b0 = nbrk;
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_data <= d;
    do @(negedge mclk); while (tx_ready !== 1'b1);
    @(posedge mclk);
    tx_valid <= 1'b0;
    u_card.get(f, brk);
    chk(f === frame(d, odd), "line frame");
    if (brk) u_card.get(f, 1'b0);
    chk(f === frame(d, odd), "resent frame");
    u_card.tick(6);
    chk(nbrk == b0 + int'(brk) && ndone == d0 + 1, "break and done counts");
  endtask : tx
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(`ADDR_PARITY_BREAK_CONTROL, `RST_PARITY_BREAK_CONTROL);
    rd(`ADDR_CHAR_TS_CONTROL, `RST_CHAR_TS_CONTROL);
    rd(16'hFE13, 8'h00);
    wr(`ADDR_PARITY_BREAK_CONTROL, 8'hFF);
    rd(`ADDR_PARITY_BREAK_CONTROL, 8'h7F);
    wr(`ADDR_PARITY_BREAK_CONTROL, 8'h00);
    u_card.tick(2);
    rx(frame(8'h3B, 1'b0), 8'h3B, 1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr(`ADDR_CHAR_TS_CONTROL, 8'h48);
      rx(k ? 9'h13B : 9'h103, k ? 8'h3B : 8'h3F, 1'b1, 1'b0);
      rd(`ADDR_CHAR_TS_CONTROL, k ? 8'h2C : 8'h0C);
    end
    for (int i = 0; i < 12; i++) begin
      lfsr = next_rand(lfsr);
      cfg = lfsr[7:0] & 8'h65;
      bad = lfsr[8];
      protocol_select <= lfsr[9];
      wr(`ADDR_PARITY_BREAK_CONTROL, cfg);
      err = !cfg[6] && (bad || cfg[0]);
      rx(frame(lfsr[23:16], bad), lfsr[23:16], !(err && cfg[2] && !lfsr[9]), err);
    end
    protocol_select <= 1'b0;
    wr(`ADDR_PARITY_BREAK_CONTROL, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_CHAR_TS_CONTROL, 8'h20 | 8'(c << 3));
      oe_cyc = 0;
      rx(frame(8'h5A, 1'b1), 8'h5A, 1'b1, 1'b1);
      chk(oe_cyc == 8 * blen[c], "break length");
      chk(io_out === 1'b0, "open drain level");
    end
    // Convention kept per card by software
    wr(`ADDR_CHAR_TS_CONTROL, 8'h28);
    tx(8'hA5, 1'b0, 1'b0);
    wr(`ADDR_PARITY_BREAK_CONTROL, 8'h02);
    tx(lfsr[7:0], 1'b0, 1'b1);
    wr(`ADDR_PARITY_BREAK_CONTROL, 8'h08);
    tx(8'h3C, 1'b1, 1'b0);
    tally_and_finish;
  end
endmodule : smart_card_char_error_control_tb
